// >>> design/acrb_cfg.svh
// Register offsets, field positions and reset values of the converter configuration bank
`ifndef ACRB_CFG_SVH
`define ACRB_CFG_SVH

// Register offsets on the serial control port
`define ACRB_OFF_CHANNEL_INDEX 13'h005
`define ACRB_OFF_POWER_MODES 13'h008
`define ACRB_OFF_ENHANCE_CTRL 13'h00c
`define ACRB_OFF_OUTPUT_MODE 13'h014
`define ACRB_OFF_OUTPUT_ADJUST 13'h015
`define ACRB_OFF_OUTPUT_PHASE 13'h016
`define ACRB_OFF_SERIAL_CTRL 13'h021
`define ACRB_OFF_TRANSFER 13'h0ff
`define ACRB_OFF_OVERRIDE 13'h100
`define ACRB_OFF_USER_IO_TWO 13'h101

// Writable bits of each register; open bits read zero
`define ACRB_MASK_INDEX 8'h0f
`define ACRB_MASK_POWER 8'h23
`define ACRB_MASK_ENHANCE 8'h04
`define ACRB_MASK_OMODE 8'h45
`define ACRB_MASK_OADJ 8'h31
`define ACRB_MASK_OPHASE 8'h7f
`define ACRB_MASK_SERIAL 8'hff
`define ACRB_MASK_OVERRIDE 8'h77
`define ACRB_MASK_USER_IO 8'h01

// Field positions
`define ACRB_BIT_PIN_FUNC 5
`define ACRB_BIT_CHOP 2
`define ACRB_BIT_IEEE 6
`define ACRB_BIT_INVERT 2
`define ACRB_BIT_TWOS 0
`define ACRB_BIT_DRIVE 0
`define ACRB_BIT_COMMIT 0
`define ACRB_BIT_OVR_EN 6
`define ACRB_BIT_PULLDN_OFF 0

// Reset values
`define ACRB_RST_ZERO 8'h00
`define ACRB_RST_SERIAL 8'h30

// Highest valid output clock phase step (660 degrees)
`define ACRB_DCO_PHASE_MAX 4'hb

`endif

// >>> design/acrb_pkg.sv
// Types shared by the converter configuration bank
package acrb_pkg;

  // Power state after combining register field and pin
  typedef enum logic [1:0] {
    ACRB_NORMAL,
    ACRB_FULL_PD,
    ACRB_STANDBY,
    ACRB_DIG_RST
  } acrb_pwr_t;

  // Per-channel output settings
  typedef struct packed {
    logic ieee_range;
    logic invert;
    logic twos_comp;
    logic [1:0] term_sel;
    logic drive_2x;
    logic [2:0] in_phase;
    logic [3:0] dco_phase;
  } acrb_chan_t;

  // Datapath power controls
  typedef struct packed {
    logic clk_en;
    logic dp_reset;
    logic out_en;
    logic out_reset;
  } acrb_pwr_ctl_t;

  // Committed rate and resolution limit
  typedef struct packed {
    logic enable;
    logic [1:0] resolution;
    logic [2:0] max_rate;
  } acrb_ovr_t;

endpackage : acrb_pkg

// >>> design/acrb_reg_bank.sv
// Configuration register bank of a four-channel serial-output converter
`timescale 1ns/1ps
`default_nettype none
`include "acrb_cfg.svh"

module acrb_reg_bank
  import acrb_pkg::*;
#(
  parameter int NCH = 4
)(
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register access from the serial control port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [12:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Device pin
  input wire logic power_down_pin_i,
  // Datapath controls
  output acrb_pwr_t pwr_mode_o,
  output acrb_pwr_ctl_t pwr_ctl_o,
  output logic chop_en_o,
  output acrb_chan_t [NCH-1:0] chan_cfg_o,
  output logic [7:0] serial_ctrl_o,
  output acrb_ovr_t ovr_o,
  output logic sdio_pulldown_en_o
);

  // Address match, shared by write and read decode
  function automatic logic hit(input logic [12:0] a, input logic [12:0] off);
    hit = (a == off);
  endfunction : hit

  // Lowest selected channel, used for per-channel read-back
  function automatic int first_sel(input logic [3:0] idx);
    first_sel = 0;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (idx[i])
        first_sel = i;
    end
  endfunction : first_sel

  logic [3:0] index_ff;
  logic [7:0] power_ff;
  logic [7:0] enh_ff;
  logic [7:0] serial_ff;
  logic [7:0] ovr_ff;
  logic [7:0] uio_ff;
  logic [7:0] omode_ff [NCH];
  logic [7:0] oadj_ff [NCH];
  logic [7:0] ophase_ff [NCH];
  acrb_ovr_t ovr_act_ff;
  logic pd_s1_ff;
  logic pd_s2_ff;
  logic pd_s3_ff;
  logic pd_lvl_ff;

  // Write strobes per register
  wire logic wr_index = reg_wr_i && hit(reg_addr_i, `ACRB_OFF_CHANNEL_INDEX);
  wire logic wr_power = reg_wr_i && hit(reg_addr_i, `ACRB_OFF_POWER_MODES);
  wire logic wr_enh = reg_wr_i && hit(reg_addr_i, `ACRB_OFF_ENHANCE_CTRL);
  wire logic wr_omode = reg_wr_i && hit(reg_addr_i, `ACRB_OFF_OUTPUT_MODE);
  wire logic wr_oadj = reg_wr_i && hit(reg_addr_i, `ACRB_OFF_OUTPUT_ADJUST);
  wire logic wr_ophase = reg_wr_i && hit(reg_addr_i, `ACRB_OFF_OUTPUT_PHASE);
  wire logic wr_serial = reg_wr_i && hit(reg_addr_i, `ACRB_OFF_SERIAL_CTRL);
  wire logic wr_xfer = reg_wr_i && hit(reg_addr_i, `ACRB_OFF_TRANSFER);
  wire logic wr_ovr = reg_wr_i && hit(reg_addr_i, `ACRB_OFF_OVERRIDE);
  wire logic wr_uio = reg_wr_i && hit(reg_addr_i, `ACRB_OFF_USER_IO_TWO);
  wire logic commit = wr_xfer && reg_wdata_i[`ACRB_BIT_COMMIT];

  // Global registers; only power-on reset clears them, never a power mode
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      index_ff <= 4'h0;
      power_ff <= `ACRB_RST_ZERO;
      enh_ff <= `ACRB_RST_ZERO;
      serial_ff <= `ACRB_RST_SERIAL;
      ovr_ff <= `ACRB_RST_ZERO;
      uio_ff <= `ACRB_RST_ZERO;
    end
    else
    begin
      if (wr_index)
        index_ff <= reg_wdata_i[3:0];
      if (wr_power)
        power_ff <= reg_wdata_i & `ACRB_MASK_POWER;
      if (wr_enh)
        enh_ff <= reg_wdata_i & `ACRB_MASK_ENHANCE;
      if (wr_serial)
        serial_ff <= reg_wdata_i & `ACRB_MASK_SERIAL;
      if (wr_ovr)
        ovr_ff <= reg_wdata_i & `ACRB_MASK_OVERRIDE;
      if (wr_uio)
        uio_ff <= reg_wdata_i & `ACRB_MASK_USER_IO;
    end
  end

  // Staged override packed into the committed layout
  wire acrb_ovr_t ovr_stage = {ovr_ff[`ACRB_BIT_OVR_EN], ovr_ff[5:4], ovr_ff[2:0]};

  // Override shadow: staged value stays inert until the transfer bit
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      ovr_act_ff <= '0;
    else if (commit)
      ovr_act_ff <= ovr_stage;
  end

  // Per-channel registers gated by the index bits
  genvar c;
  generate
    for (c = 0; c < NCH; c++)
    begin : g_chan
      always_ff @(posedge clk_i)
      begin
        if (reset_i)
        begin
          omode_ff[c] <= `ACRB_RST_ZERO;
          oadj_ff[c] <= `ACRB_RST_ZERO;
          ophase_ff[c] <= `ACRB_RST_ZERO;
        end
        else if (index_ff[c])
        begin
          if (wr_omode)
            omode_ff[c] <= reg_wdata_i & `ACRB_MASK_OMODE;
          if (wr_oadj)
            oadj_ff[c] <= reg_wdata_i & `ACRB_MASK_OADJ;
          if (wr_ophase)
            ophase_ff[c] <= reg_wdata_i & `ACRB_MASK_OPHASE;
        end
      end

      // Effective settings; termination wins over 2x drive
      wire logic term_on = |oadj_ff[c][5:4];
      wire logic [3:0] dco_raw = ophase_ff[c][3:0];
      wire logic dco_over = dco_raw > `ACRB_DCO_PHASE_MAX;
      acrb_chan_t nxt_cfg;
      assign nxt_cfg.ieee_range = omode_ff[c][`ACRB_BIT_IEEE];
      assign nxt_cfg.invert = omode_ff[c][`ACRB_BIT_INVERT];
      assign nxt_cfg.twos_comp = omode_ff[c][`ACRB_BIT_TWOS];
      assign nxt_cfg.term_sel = oadj_ff[c][5:4];
      assign nxt_cfg.drive_2x = oadj_ff[c][`ACRB_BIT_DRIVE] && !term_on;
      assign nxt_cfg.in_phase = ophase_ff[c][6:4];
      // Unused codes above 660 degrees hold at the last valid step
      assign nxt_cfg.dco_phase = dco_over ? `ACRB_DCO_PHASE_MAX : dco_raw;

      always_ff @(posedge clk_i)
      begin
        if (reset_i)
          chan_cfg_o[c] <= '0;
        else
          chan_cfg_o[c] <= nxt_cfg;
      end
    end
  endgenerate

  // Pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pd_s1_ff <= 1'b0;
      pd_s2_ff <= 1'b0;
      pd_s3_ff <= 1'b0;
      pd_lvl_ff <= 1'b0;
    end
    else
    begin
      pd_s1_ff <= power_down_pin_i;
      pd_s2_ff <= pd_s1_ff;
      pd_s3_ff <= pd_s2_ff;
      if (pd_s2_ff == pd_s3_ff)
        pd_lvl_ff <= pd_s3_ff;
    end
  end

  // Power state: an asserted pin overrides the register field
  wire logic pin_stby = power_ff[`ACRB_BIT_PIN_FUNC];
  wire logic [1:0] pwr_field = power_ff[1:0];
  acrb_pwr_t nxt_mode;
  acrb_pwr_ctl_t nxt_ctl;
  always_comb
  begin
    if (pd_lvl_ff)
      nxt_mode = pin_stby ? ACRB_STANDBY : ACRB_FULL_PD;
    else
    begin
      case (pwr_field)
        2'h0: nxt_mode = ACRB_NORMAL;
        2'h1: nxt_mode = ACRB_FULL_PD;
        2'h2: nxt_mode = ACRB_STANDBY;
        2'h3: nxt_mode = ACRB_DIG_RST;
        default: nxt_mode = ACRB_NORMAL;
      endcase
    end
  end

  // Datapath controls per state; control port is never among them
  always_comb
  begin
    case (nxt_mode)
      ACRB_NORMAL: nxt_ctl = '{1'b1, 1'b0, 1'b1, 1'b0};
      ACRB_FULL_PD: nxt_ctl = '{1'b0, 1'b1, 1'b0, 1'b0};
      ACRB_STANDBY: nxt_ctl = '{1'b0, 1'b0, 1'b0, 1'b0};
      ACRB_DIG_RST: nxt_ctl = '{1'b0, 1'b1, 1'b0, 1'b1};
      default: nxt_ctl = '{1'b1, 1'b0, 1'b1, 1'b0};
    endcase
  end

  // Read mux; per-channel reads show the lowest selected channel
  int rsel;
  assign rsel = first_sel(index_ff);
  logic [7:0] nxt_rdata;
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (hit(reg_addr_i, `ACRB_OFF_CHANNEL_INDEX))
      nxt_rdata = {4'h0, index_ff};
    else if (hit(reg_addr_i, `ACRB_OFF_POWER_MODES))
      nxt_rdata = power_ff;
    else if (hit(reg_addr_i, `ACRB_OFF_ENHANCE_CTRL))
      nxt_rdata = enh_ff;
    else if (hit(reg_addr_i, `ACRB_OFF_OUTPUT_MODE))
      nxt_rdata = omode_ff[rsel];
    else if (hit(reg_addr_i, `ACRB_OFF_OUTPUT_ADJUST))
      nxt_rdata = oadj_ff[rsel];
    else if (hit(reg_addr_i, `ACRB_OFF_OUTPUT_PHASE))
      nxt_rdata = ophase_ff[rsel];
    else if (hit(reg_addr_i, `ACRB_OFF_SERIAL_CTRL))
      nxt_rdata = serial_ff;
    else if (hit(reg_addr_i, `ACRB_OFF_OVERRIDE))
      nxt_rdata = ovr_ff;
    else if (hit(reg_addr_i, `ACRB_OFF_USER_IO_TWO))
      nxt_rdata = uio_ff;
  end

  // Output flops; transfer reads zero since it has no entry in the read mux
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      reg_rdata_o <= 8'h00;
      pwr_mode_o <= ACRB_NORMAL;
      pwr_ctl_o <= '{1'b1, 1'b0, 1'b1, 1'b0};
      chop_en_o <= 1'b0;
      serial_ctrl_o <= `ACRB_RST_SERIAL;
      ovr_o <= '0;
      sdio_pulldown_en_o <= 1'b1;
    end
    else
    begin
      if (reg_rd_i)
        reg_rdata_o <= nxt_rdata;
      pwr_mode_o <= nxt_mode;
      pwr_ctl_o <= nxt_ctl;
      chop_en_o <= enh_ff[`ACRB_BIT_CHOP];
      serial_ctrl_o <= serial_ff;
      ovr_o <= ovr_act_ff;
      sdio_pulldown_en_o <= !uio_ff[`ACRB_BIT_PULLDN_OFF];
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Commit loads the staged override within two cycles
  sequence s_commit;
    commit && !wr_ovr;
  endsequence
  override_commit_a: assert property (s_commit |=> ##1 ovr_o == $past(ovr_stage, 2))
    else $error("override not committed");

  // Staged override alone leaves the active value alone
  override_hold_a: assert property (wr_ovr && !commit |=> $stable(ovr_act_ff))
    else $error("override changed without transfer");

  // Pin with standby function leads to standby, controls follow
  pin_standby_a: assert property (pd_lvl_ff && pin_stby |=> pwr_mode_o == ACRB_STANDBY
    && !pwr_ctl_o.out_en && !pwr_ctl_o.dp_reset)
    else $error("pin standby wrong");

  // Pin without standby function leads to full power-down
  pin_fulldown_a: assert property (pd_lvl_ff && !pin_stby |=> pwr_mode_o == ACRB_FULL_PD
    && pwr_ctl_o.dp_reset && !pwr_ctl_o.clk_en)
    else $error("pin power-down wrong");

  // Normal field with pin idle keeps datapath alive
  normal_run_a: assert property (!pd_lvl_ff && pwr_field == 2'h0 |=> pwr_ctl_o.clk_en
    && pwr_ctl_o.out_en && !pwr_ctl_o.dp_reset)
    else $error("normal mode controls wrong");

  // Digital reset still lets the control port write the index
  port_alive_a: assert property (pwr_mode_o == ACRB_DIG_RST && wr_index
    |=> index_ff == $past(reg_wdata_i[3:0]))
    else $error("control port blocked in reset mode");

  // Unselected channel ignores per-channel writes
  index_gate_a: assert property (wr_omode && !index_ff[0] |=> $stable(omode_ff[0]))
    else $error("unselected channel written");

  // Termination blocks 2x drive on the output
  drive_prec_a: assert property (|oadj_ff[0][5:4] |=> !chan_cfg_o[0].drive_2x)
    else $error("2x drive with termination");

  // Inversion and format reach the output two cycles after a write
  omode_path_a: assert property (wr_omode && index_ff[0] |=> ##1
    chan_cfg_o[0].invert == $past(reg_wdata_i[2], 2)
    && chan_cfg_o[0].twos_comp == $past(reg_wdata_i[0], 2))
    else $error("output mode not applied");

  // Open bits of power register read as zero
  open_bits_a: assert property (reg_rd_i && hit(reg_addr_i, `ACRB_OFF_POWER_MODES)
    |=> reg_rdata_o[7:6] == 2'h0 && reg_rdata_o[4:2] == 3'h0)
    else $error("open bits not zero");

  // Writes that land in channel zero
  sequence s_ch0_oadj;
    wr_oadj && index_ff[0];
  endsequence
  sequence s_ch0_ophase;
    wr_ophase && index_ff[0];
  endsequence

  // Termination and sampling phase reach the output two cycles after a write
  term_path_a: assert property (s_ch0_oadj |=> ##1
    chan_cfg_o[0].term_sel == $past(reg_wdata_i[5:4], 2))
    else $error("termination not applied");
  in_phase_path_a: assert property (s_ch0_ophase |=> ##1
    chan_cfg_o[0].in_phase == $past(reg_wdata_i[6:4], 2))
    else $error("input phase not applied");

  // Codes past the last step hold there; valid codes pass untouched
  dco_clamp_a: assert property (ophase_ff[0][3:0] > `ACRB_DCO_PHASE_MAX |=>
    chan_cfg_o[0].dco_phase == `ACRB_DCO_PHASE_MAX)
    else $error("phase code not clamped");
  dco_pass_a: assert property (ophase_ff[0][3:0] <= `ACRB_DCO_PHASE_MAX |=>
    chan_cfg_o[0].dco_phase == $past(ophase_ff[0][3:0]))
    else $error("phase code altered");

  // Chopping follows its bit straight away, no commit needed
  chop_path_a: assert property (wr_enh |=> ##1
    chop_en_o == $past(reg_wdata_i[`ACRB_BIT_CHOP], 2))
    else $error("chop bit not applied");

  // Pull-down is connected unless its disable bit was written one
  pulldown_path_a: assert property (wr_uio |=> ##1
    sdio_pulldown_en_o == !$past(reg_wdata_i[`ACRB_BIT_PULLDN_OFF], 2))
    else $error("pull-down control wrong");

  // Register field codes with the pin idle
  field_fulldown_a: assert property (!pd_lvl_ff && pwr_field == 2'h1 |=>
    !pwr_ctl_o.clk_en && pwr_ctl_o.dp_reset && !pwr_ctl_o.out_en)
    else $error("full power-down controls wrong");
  field_standby_a: assert property (!pd_lvl_ff && pwr_field == 2'h2 |=>
    !pwr_ctl_o.clk_en && !pwr_ctl_o.dp_reset && !pwr_ctl_o.out_en)
    else $error("standby controls wrong");
  field_digrst_a: assert property (!pd_lvl_ff && pwr_field == 2'h3 |=>
    pwr_ctl_o.dp_reset && pwr_ctl_o.out_reset && !pwr_ctl_o.out_en)
    else $error("digital reset controls wrong");

endmodule : acrb_reg_bank
`default_nettype wire

// >>> bench/acrb_host_model.sv
// Host controller model driving the register port of the configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "acrb_cfg.svh"

module acrb_host_model #(
  parameter logic [2:0] DIV_SETTING = 3'h3
)(
  // Clock
  input wire logic clk_i,
  // Register port towards the bank
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [12:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);

  // Idle port at time zero
  initial
  begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 13'h1fff;
    reg_wdata_o = 8'h5a;
  end

  // One write, held through the edge that takes it
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    // Sampling phase must not pass the divider setting
    if (a == `ACRB_OFF_OUTPUT_PHASE && v[6:4] > DIV_SETTING)
      v[6:4] = DIV_SETTING;
    @(posedge clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= v;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    // Released lines flip so stale values cannot pass for good ones
    reg_addr_o <= ~a;
    reg_wdata_o <= ~v;
  endtask : wr

  // One read; data is registered and taken a cycle after the strobe
  task automatic rd(input logic [12:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge clk_i);
    #1;
    d = reg_rdata_i;
  endtask : rd

endmodule : acrb_host_model
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking bench for the converter configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "acrb_cfg.svh"

module tb_top
  import acrb_pkg::*;
;
  `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end

  typedef struct packed {
    logic [12:0] addr;
    logic [7:0] rst;
    logic [7:0] wdata;
    logic [7:0] rdata;
  } acrb_row_t;

  // Reset value, write value and masked read-back of each place
  localparam acrb_row_t ROWS [11] = '{
    '{`ACRB_OFF_CHANNEL_INDEX, 8'h00, 8'hff, 8'h0f},
    '{`ACRB_OFF_POWER_MODES, 8'h00, 8'hff, 8'h23},
    '{`ACRB_OFF_ENHANCE_CTRL, 8'h00, 8'hff, 8'h04},
    '{`ACRB_OFF_OUTPUT_MODE, 8'h00, 8'hff, 8'h45},
    '{`ACRB_OFF_OUTPUT_ADJUST, 8'h00, 8'hff, 8'h31},
    '{`ACRB_OFF_OUTPUT_PHASE, 8'h00, 8'hbf, 8'h3f},
    '{`ACRB_OFF_SERIAL_CTRL, 8'h30, 8'ha5, 8'ha5},
    '{`ACRB_OFF_OVERRIDE, 8'h00, 8'hff, 8'h77},
    '{`ACRB_OFF_USER_IO_TWO, 8'h00, 8'hff, 8'h01},
    '{`ACRB_OFF_TRANSFER, 8'h00, 8'h01, 8'h00},
    '{13'h030, 8'h00, 8'hff, 8'h00}
  };
  localparam logic [3:0] CTL_TAB [4] = '{4'ha, 4'h4, 4'h0, 4'h5};

  logic clk_i;
  logic reset_i;
  logic pin;
  logic wr;
  logic rd;
  logic [12:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] v;
  acrb_pwr_t pwr_mode;
  acrb_pwr_ctl_t pwr_ctl;
  logic chop;
  acrb_chan_t [3:0] chan;
  logic [7:0] serial;
  acrb_ovr_t ovr;
  logic pdn;
  int failures = 0;
  int total_checks = 0;

  acrb_host_model host (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata));

  acrb_reg_bank #(.NCH(4)) dut (.clk_i(clk_i), .reset_i(reset_i), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .power_down_pin_i(pin), .pwr_mode_o(pwr_mode), .pwr_ctl_o(pwr_ctl), .chop_en_o(chop),
    .chan_cfg_o(chan), .serial_ctrl_o(serial), .ovr_o(ovr), .sdio_pulldown_en_o(pdn));

  // 40 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // Outputs follow a write one edge after it is taken; settle waits two edges
  task automatic settle;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : settle

  // Pin passes a synchroniser, so the wait is bounded, not fixed
  task automatic wait_mode(input acrb_pwr_t m);
    for (int n = 0; n < 12; n++)
    begin
      @(posedge clk_i);
      #1;
      if (pwr_mode === m)
        break;
    end
    `CHK(pwr_mode, m)
  endtask : wait_mode

  function automatic acrb_chan_t mk_chan(input logic [2:0] fl, input logic [1:0] t,
    input logic d, input logic [2:0] p, input logic [3:0] c);
    mk_chan = {fl, t, d, p, c};
  endfunction : mk_chan

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    reset_i = 1'b1;
    pin = 1'b0;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    `CHK(pwr_ctl, 4'ha)
    `CHK(pdn, 1'b1)
    for (int i = 0; i < 11; i++)
    begin
      host.rd(ROWS[i].addr, v);
      `CHK(v, ROWS[i].rst)
      host.wr(ROWS[i].addr, ROWS[i].wdata);
      host.rd(ROWS[i].addr, v);
      `CHK(v, ROWS[i].rdata)
    end
    settle();
    `CHK(pwr_mode, ACRB_DIG_RST)
    `CHK(chop, 1'b1)
    `CHK(serial, 8'ha5)
    `CHK(ovr, 6'h3f)
    `CHK(pdn, 1'b0)
    for (int c = 0; c < 4; c++)
      `CHK(chan[c], mk_chan(3'h7, 2'h3, 1'b0, 3'h3, 4'hb))
    // Staged override stays out until committed
    host.wr(`ACRB_OFF_OVERRIDE, 8'h15);
    settle();
    `CHK(ovr, 6'h3f)
    host.rd(`ACRB_OFF_OVERRIDE, v);
    `CHK(v, 8'h15)
    host.wr(`ACRB_OFF_TRANSFER, 8'h00);
    settle();
    `CHK(ovr, 6'h3f)
    host.wr(`ACRB_OFF_TRANSFER, 8'h01);
    settle();
    `CHK(ovr, 6'h0d)
    // Every internal power field code
    for (int f = 0; f < 4; f++)
    begin
      host.wr(`ACRB_OFF_POWER_MODES, 8'(f));
      settle();
      `CHK(pwr_ctl, CTL_TAB[f])
      `CHK(pwr_mode, acrb_pwr_t'(f))
    end
    host.wr(`ACRB_OFF_POWER_MODES, 8'h20);
    @(posedge clk_i) pin <= 1'b1;
    wait_mode(ACRB_STANDBY);
    host.wr(`ACRB_OFF_POWER_MODES, 8'h00);
    wait_mode(ACRB_FULL_PD);
    @(posedge clk_i) pin <= 1'b0;
    wait_mode(ACRB_NORMAL);
    // Per-channel writes reach only the indexed channel
    host.wr(`ACRB_OFF_CHANNEL_INDEX, 8'h02);
    host.wr(`ACRB_OFF_OUTPUT_MODE, 8'h00);
    settle();
    `CHK(chan[1].invert, 1'b0)
    `CHK(chan[0].invert, 1'b1)
    host.rd(`ACRB_OFF_OUTPUT_MODE, v);
    `CHK(v, 8'h00)
    host.wr(`ACRB_OFF_CHANNEL_INDEX, 8'h14);
    host.wr(`ACRB_OFF_OUTPUT_ADJUST, 8'h01);
    settle();
    `CHK(chan[2].drive_2x, 1'b1)
    `CHK(chan[3].drive_2x, 1'b0)
    `CHK(chan[1].term_sel, 2'h3)
    host.wr(`ACRB_OFF_OUTPUT_PHASE, 8'h75);
    settle();
    `CHK(chan[2].in_phase, 3'h3)
    `CHK(chan[2].dco_phase, 4'h5)
    `CHK(chan[1], mk_chan(3'h0, 2'h3, 1'b0, 3'h3, 4'hb))
    // Mid-run power-on reset restores the bank
    @(posedge clk_i) reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    #1;
    `CHK(serial, 8'h30)
    `CHK(ovr, 6'h00)
    `CHK(chan[2], 13'h0000)
    `CHK(pdn, 1'b1)
    `CHK(pwr_ctl, 4'ha)
    host.rd(`ACRB_OFF_SERIAL_CTRL, v);
    `CHK(v, 8'h30)
    tally_and_finish();
  end

endmodule : tb_top
`default_nettype wire
